/* verilog/bapsq_top.sv */
// brake-after-park sequencer with supply reset, thermal shutdown and AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] supply fault, thermal shutdown or sleep raises fault and starts actuator park
// [R2] park forces spindle stage high impedance with no software action
// [R3] park turns negative VCM low side fully on, all other VCM drivers off
// [R4] stay in park while brake-delay comparator reports node above threshold
// [R5] once below threshold, short brake-delay node to ground throughout brake
// [R6] during brake, precharge both VCM outputs and short VCM command input
// [R7] during precharge, negative VCM low side driver is off
// [R8] during precharge, park circuitry is powered down
// [R9] spindle brake starts when brake-delay comparator falls below threshold
// [R10] brake: all three spindle low sides on, all high sides off
// [R11] hold brake-after-park until software writes 1 to spin-enable, ctrl1 bit 3
// [R12] reset output rises after both supplies good plus delay, falls on any fail
// [R13] while reset output is low, brake-after-park is forced
// [R14] after reset release, keep brake-after-park until software requests start
// [R15] reset is synchronous; load ctrl0 and ctrl1 defaults when it releases
// [R16] with reset held low, one clock edge loads the defaults
// [R17] short supply spikes do not assert reset
// [R18] over-temperature trip enters brake-after-park and drives temp output high
// [R19] thermal shutdown holds until temperature falls below limit minus hysteresis
// [R20] ctrl1 bit selects high-gain seek or low-gain track-following path
// [R21] software should set spindle high impedance between brake and run; no register bit sets spindle_hiz, brake goes straight to run with it low
// [R22] brake-delay and over-temperature inputs pass two flip-flops first
// [R23] states run, park, brake; run is entered only from brake
module bapsq_top
	import bapsq_pkg::*;
#(
	parameter int POR_DLY_CYC = BAPSQ_POR_DLY_CYC // supply-good delay in cycles
) (
	input  wire logic                      aclk,           // 200 MHz clock
	input  wire logic                      aresetn,        // sync reset, active low
	input  wire logic                      clk_en,         // freezes all state when low
	input  wire bapsq_pkg::bapsq_axi_req_t axi_req,        // AXI4-Lite master side
	output var  bapsq_pkg::bapsq_axi_rsp_t axi_rsp,        // AXI4-Lite slave side
	input  wire logic                      low_supply_check,  // 5 V supply above threshold
	input  wire logic                      high_supply_check, // 12 V supply above threshold
	input  wire logic                      brake_delay_above, // brake_delay_node comparator
	input  wire logic                      temp_over,      // over-temp, hysteresis in analog
	output var  logic                      por_n,          // supply reset output, active low
	output var  logic                      fault,          // safety fault
	output var  logic                      temp_alarm,     // temperature output high
	output var  bapsq_pkg::bapsq_drive_t   drive           // power-stage commands
);
	import bapsq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	localparam int GLW = $clog2(BAPSQ_GLITCH_CYC + 1);
	localparam int PDW = $clog2(POR_DLY_CYC + 1);

	typedef struct packed {
		logic [3:0]     bd_sync;   // [1:0] brake delay, [3:2] over-temp
		logic [3:0]     sup_sync;  // [1:0] low supply, [3:2] high supply
		logic [GLW-1:0] glitch_cnt;
		logic           sup_ok;
		logic [PDW-1:0] por_cnt;
		logic           por_n;
		logic           por_seen;
		logic           tsd;
		bapsq_state_t   state;
		logic [11:0]    ctrl0;
		logic [11:0]    ctrl1;
		logic           spin_req;
		logic           fault;
		bapsq_drive_t   drive;
		bapsq_axi_rsp_t axi;
		logic           aw_got;
		logic           w_got;
		logic [7:0]     waddr;
		logic [31:0]    wdata;
	} bapsq_st_t;

	bapsq_st_t st_r;
	bapsq_st_t st_nxt;

	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) &&
			(a[7:0] <= BAPSQ_STATUS_OFF);
	endfunction : addr_ok

	////////////////////////////////////////////////////////////////////////////////
	logic bd_above;
	logic ot;
	logic sup_raw_ok;
	logic fault_cond;

	assign bd_above   = st_r.bd_sync[1];                                  // R22
	assign ot         = st_r.bd_sync[3];                                  // R22
	assign sup_raw_ok = st_r.sup_sync[1] & st_r.sup_sync[3];
	// sleep from control register 1 joins supply and thermal faults
	assign fault_cond = ~st_r.por_n | st_r.tsd | st_r.ctrl1[BAPSQ_SLEEP_BIT]; // R1 R13 R18

	always_comb begin
		st_nxt = st_r;
		if (clk_en) begin
			st_nxt.bd_sync  = {st_r.bd_sync[2], temp_over, st_r.bd_sync[0], brake_delay_above};
			st_nxt.sup_sync = {st_r.sup_sync[2], high_supply_check,
				st_r.sup_sync[0], low_supply_check};

			// a failing supply must persist before it counts, spikes are ignored
			if (sup_raw_ok) begin
				st_nxt.glitch_cnt = '0;
				st_nxt.sup_ok     = 1'b1;
			end else if (st_r.glitch_cnt == GLW'(BAPSQ_GLITCH_CYC)) begin
				st_nxt.sup_ok = 1'b0;                                          // R17
			end else begin
				st_nxt.glitch_cnt = st_r.glitch_cnt + GLW'(1);                 // R17
			end

			if (!st_r.sup_ok) begin
				st_nxt.por_cnt = '0;
				st_nxt.por_n   = 1'b0;                                         // R12
			end else if (st_r.por_cnt == PDW'(POR_DLY_CYC)) begin
				st_nxt.por_n = 1'b1;                                           // R12
			end else begin
				st_nxt.por_cnt = st_r.por_cnt + PDW'(1);
			end

			// the comparator carries the analog hysteresis, so follow it directly
			st_nxt.tsd = ot;                                                   // R18 R19

			// defaults while the reset output is low and on its release
			st_nxt.por_seen = st_r.por_n;
			if (!st_r.por_n || !st_r.por_seen) begin
				st_nxt.ctrl0    = BAPSQ_CTRL0_RST;                             // R15 R16
				st_nxt.ctrl1    = BAPSQ_CTRL1_RST;                             // R15 R16
				st_nxt.spin_req = 1'b0;                                        // R14
			end

			// AXI4-Lite write
			if (axi_req.awvalid && st_r.axi.awready) begin
				st_nxt.aw_got      = 1'b1;
				st_nxt.waddr       = axi_req.awaddr[7:0];
				st_nxt.axi.awready = 1'b0;
			end
			if (axi_req.wvalid && st_r.axi.wready) begin
				st_nxt.w_got      = 1'b1;
				st_nxt.wdata      = axi_req.wdata;
				st_nxt.axi.wready = 1'b0;
			end
			if (st_r.aw_got && st_r.w_got && !st_r.axi.bvalid) begin
				st_nxt.axi.bvalid = 1'b1;
				st_nxt.axi.bresp  = (st_r.waddr == BAPSQ_CTRL0_OFF ||
					st_r.waddr == BAPSQ_CTRL1_OFF) ? BAPSQ_RESP_OKAY : BAPSQ_RESP_SLVERR;
				if (st_r.por_n && st_r.por_seen) begin
					if (st_r.waddr == BAPSQ_CTRL0_OFF)
						st_nxt.ctrl0 = st_r.wdata[11:0];
					if (st_r.waddr == BAPSQ_CTRL1_OFF) begin
						st_nxt.ctrl1 = st_r.wdata[11:0];
						if (st_r.wdata[BAPSQ_SPIN_EN_BIT])
							st_nxt.spin_req = 1'b1;                            // R11
					end
				end
			end
			if (st_r.axi.bvalid && axi_req.bready) begin
				st_nxt.axi.bvalid  = 1'b0;
				st_nxt.aw_got      = 1'b0;
				st_nxt.w_got       = 1'b0;
				st_nxt.axi.awready = 1'b1;
				st_nxt.axi.wready  = 1'b1;
			end

			// AXI4-Lite read
			if (axi_req.arvalid && st_r.axi.arready) begin
				st_nxt.axi.arready = 1'b0;
				st_nxt.axi.rvalid  = 1'b1;
				st_nxt.axi.rresp   = addr_ok(axi_req.araddr) ? BAPSQ_RESP_OKAY
					: BAPSQ_RESP_SLVERR;
				case (axi_req.araddr[7:0])
					BAPSQ_CTRL0_OFF:  st_nxt.axi.rdata = {20'h00000, st_r.ctrl0};
					BAPSQ_CTRL1_OFF:  st_nxt.axi.rdata = {20'h00000, st_r.ctrl1};
					BAPSQ_STATUS_OFF: st_nxt.axi.rdata = {24'h000000, st_r.spin_req,
						st_r.tsd, st_r.por_n, st_r.fault, bd_above, 1'b0, st_r.state};
					default:          st_nxt.axi.rdata = 32'h00000000;
				endcase
			end
			if (st_r.axi.rvalid && axi_req.rready) begin
				st_nxt.axi.rvalid  = 1'b0;
				st_nxt.axi.arready = 1'b1;
			end

			// sequencer
			case (st_r.state)
				BAPSQ_RUN: begin
					if (fault_cond) begin
						st_nxt.state    = BAPSQ_PARK;                          // R1
						// a request left from running must not end a later brake
						st_nxt.spin_req = st_nxt.spin_req & ~st_r.spin_req;    // R11
					end
				end
				BAPSQ_PARK: begin
					if (!bd_above)
						st_nxt.state = BAPSQ_BRAKE;                            // R4 R9
				end
				BAPSQ_BRAKE: begin
					if (st_r.spin_req && !fault_cond) begin
						st_nxt.state    = BAPSQ_RUN;                           // R11 R23
						st_nxt.spin_req = 1'b0;
					end
				end
				default: st_nxt.state = BAPSQ_PARK;
			endcase
			st_nxt.fault = fault_cond;                                         // R1

			st_nxt.drive = '0;
			st_nxt.drive.seek_gain_sel = ~st_nxt.ctrl1[BAPSQ_TRACKFW_BIT];     // R20
			case (st_nxt.state)
				BAPSQ_RUN: begin
					st_nxt.drive.vcm_others_on = 1'b1;
					st_nxt.drive.park_circ_en  = 1'b1;
				end
				BAPSQ_PARK: begin
					st_nxt.drive.spindle_hiz   = 1'b1;                         // R2
					st_nxt.drive.vcm_neg_ls_on = 1'b1;                         // R3
					st_nxt.drive.park_circ_en  = 1'b1;
				end
				BAPSQ_BRAKE: begin
					st_nxt.drive.brake_dly_short = 1'b1;                       // R5
					st_nxt.drive.vcm_precharge   = 1'b1;                       // R6 R7 R8
					st_nxt.drive.vcm_cmd_short   = 1'b1;                       // R6
					st_nxt.drive.spindle_ls_on   = 3'h7;                       // R10
				end
				default: st_nxt.drive.spindle_hiz = 1'b1;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r              <= '0;
			// the rc node idles above threshold, so no brake before the comparator is seen
			st_r.bd_sync      <= 4'h3;
			st_r.state        <= BAPSQ_PARK;
			st_r.fault        <= 1'b1;
			st_r.ctrl0        <= BAPSQ_CTRL0_RST;
			st_r.ctrl1        <= BAPSQ_CTRL1_RST;
			st_r.drive.spindle_hiz   <= 1'b1;
			st_r.drive.vcm_neg_ls_on <= 1'b1;
			st_r.drive.park_circ_en  <= 1'b1;
			st_r.drive.seek_gain_sel <= 1'b1;
			st_r.axi.awready  <= 1'b1;
			st_r.axi.wready   <= 1'b1;
			st_r.axi.arready  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign axi_rsp    = st_r.axi;
	assign por_n      = st_r.por_n;
	assign fault      = st_r.fault;
	assign temp_alarm = st_r.tsd;
	assign drive      = st_r.drive;

	////////////////////////////////////////////////////////////////////////////////
	property p_por_low_forces;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && !st_r.por_n && st_r.state == BAPSQ_RUN) |=> st_r.state == BAPSQ_PARK;
	endproperty
	a_por_low_forces: assert property (p_por_low_forces) else $error("run kept under reset"); // R13

	property p_park_drive;
		@(posedge aclk) disable iff (!aresetn)
		(st_r.state == BAPSQ_PARK && $past(st_r.state) == BAPSQ_PARK) |->
			st_r.drive.spindle_hiz && st_r.drive.vcm_neg_ls_on && !st_r.drive.vcm_others_on;
	endproperty
	a_park_drive: assert property (p_park_drive) else $error("park drive wrong"); // R3

	property p_brake_drive;
		@(posedge aclk) disable iff (!aresetn)
		st_r.state == BAPSQ_BRAKE |-> st_r.drive.spindle_ls_on == 3'h7 &&
			st_r.drive.spindle_hs_on == 3'h0 && !st_r.drive.vcm_neg_ls_on &&
			!st_r.drive.park_circ_en && st_r.drive.brake_dly_short;
	endproperty
	a_brake_drive: assert property (p_brake_drive) else $error("brake drive wrong"); // R10

	property p_park_holds;
		@(posedge aclk) disable iff (!aresetn)
		(st_r.state == BAPSQ_PARK && bd_above) |=> st_r.state == BAPSQ_PARK;
	endproperty
	a_park_holds: assert property (p_park_holds) else $error("park left early"); // R4

	property p_brake_after_delay;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_r.state == BAPSQ_PARK && !bd_above) |=> st_r.state == BAPSQ_BRAKE;
	endproperty
	a_brake_after_delay: assert property (p_brake_after_delay) else $error("no brake"); // R9

	property p_run_only_from_brake;
		@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.state == BAPSQ_RUN) |-> $past(st_r.state) == BAPSQ_BRAKE && !$past(fault_cond);
	endproperty
	a_run_only_from_brake: assert property (p_run_only_from_brake) else $error("bad run"); // R23

	property p_supply_fail;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && !st_r.sup_ok) |=> !st_r.por_n;
	endproperty
	a_supply_fail: assert property (p_supply_fail) else $error("reset out not low"); // R12

	property p_temp_alarm;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_r.tsd && ot && st_r.state == BAPSQ_RUN) |=>
			st_r.state == BAPSQ_PARK && temp_alarm;
	endproperty
	a_temp_alarm: assert property (p_temp_alarm) else $error("thermal trip missed"); // R18

	sequence s_park_ends;
		clk_en && st_r.state == BAPSQ_PARK && !bd_above;
	endsequence

	sequence s_braking;
		st_r.state == BAPSQ_BRAKE && st_r.drive.brake_dly_short &&
			st_r.drive.vcm_precharge && st_r.drive.vcm_cmd_short;
	endsequence

	property p_precharge_on_brake;
		@(posedge aclk) disable iff (!aresetn)
		s_park_ends |=> s_braking;
	endproperty
	a_precharge_on_brake: assert property (p_precharge_on_brake) else $error("no precharge"); // R6

	property p_park_entry;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_r.state == BAPSQ_RUN && fault_cond) |=>
			st_r.state == BAPSQ_PARK && st_r.drive.spindle_hiz && st_r.fault;
	endproperty
	a_park_entry: assert property (p_park_entry) else $error("park not entered"); // R2

	property p_precharge_neg_off;
		@(posedge aclk) disable iff (!aresetn)
		st_r.drive.vcm_precharge |-> !st_r.drive.vcm_neg_ls_on;
	endproperty
	a_precharge_neg_off: assert property (p_precharge_neg_off) else $error("neg low side on"); // R7

	property p_precharge_park_off;
		@(posedge aclk) disable iff (!aresetn)
		st_r.drive.vcm_precharge |-> !st_r.drive.park_circ_en;
	endproperty
	a_precharge_park_off: assert property (p_precharge_park_off) else $error("park powered"); // R8

	property p_brake_holds;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_r.state == BAPSQ_BRAKE && !st_r.spin_req) |=> st_r.state == BAPSQ_BRAKE;
	endproperty
	a_brake_holds: assert property (p_brake_holds) else $error("brake left early"); // R11

	property p_por_rise;
		@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.por_n) |-> $past(st_r.sup_ok) && $past(st_r.por_cnt) == PDW'(POR_DLY_CYC);
	endproperty
	a_por_rise: assert property (p_por_rise) else $error("reset out rose early"); // R12

	property p_por_low_defaults;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && !st_r.por_n) |=>
			st_r.ctrl0 == BAPSQ_CTRL0_RST && st_r.ctrl1 == BAPSQ_CTRL1_RST;
	endproperty
	a_por_low_defaults: assert property (p_por_low_defaults) else $error("no defaults"); // R16

	property p_spike_ignored;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_r.sup_ok && st_r.glitch_cnt != GLW'(BAPSQ_GLITCH_CYC)) |=> st_r.sup_ok;
	endproperty
	a_spike_ignored: assert property (p_spike_ignored) else $error("spike dropped supply"); // R17

	property p_tsd_follows;
		@(posedge aclk) disable iff (!aresetn)
		clk_en |=> st_r.tsd == $past(ot);
	endproperty
	a_tsd_follows: assert property (p_tsd_follows) else $error("shutdown not following"); // R19

	property p_gain_select;
		@(posedge aclk) disable iff (!aresetn)
		st_r.drive.seek_gain_sel == !st_r.ctrl1[BAPSQ_TRACKFW_BIT];
	endproperty
	a_gain_select: assert property (p_gain_select) else $error("gain path wrong"); // R20

	property p_sync_two;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en ##1 clk_en) |=>
			bd_above == $past(brake_delay_above, 2) && ot == $past(temp_over, 2);
	endproperty
	a_sync_two: assert property (p_sync_two) else $error("sync depth wrong"); // R22

endmodule : bapsq_top
`default_nettype wire

/* pkg/bapsq_pkg.sv */
// package for the brake-after-park sequencer: register map, reset values, types
package bapsq_pkg;

	// register byte offsets
	localparam logic [7:0] BAPSQ_CTRL0_OFF  = 8'h00;
	localparam logic [7:0] BAPSQ_CTRL1_OFF  = 8'h04;
	localparam logic [7:0] BAPSQ_STATUS_OFF = 8'h08;

	// control register 1 field positions
	localparam int BAPSQ_SPIN_EN_BIT = 3;
	localparam int BAPSQ_TRACKFW_BIT = 9;
	localparam int BAPSQ_SLEEP_BIT   = 0;

	// control register values after reset
	localparam logic [11:0] BAPSQ_CTRL0_RST = 12'h000;
	localparam logic [11:0] BAPSQ_CTRL1_RST = 12'h000;

	// supply-good delay before reset release and supply glitch filter
	localparam int BAPSQ_CLK_MHZ     = 200;
	localparam int BAPSQ_POR_DLY_US  = 100;
	localparam int BAPSQ_POR_DLY_CYC = BAPSQ_POR_DLY_US * BAPSQ_CLK_MHZ;
	localparam int BAPSQ_GLITCH_NS   = 50;
	localparam int BAPSQ_GLITCH_CYC  = BAPSQ_GLITCH_NS * BAPSQ_CLK_MHZ / 1000;

	// AXI4-Lite responses
	localparam logic [1:0] BAPSQ_RESP_OKAY   = 2'h0;
	localparam logic [1:0] BAPSQ_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		BAPSQ_RUN,
		BAPSQ_PARK,
		BAPSQ_BRAKE
	} bapsq_state_t;

	// power-stage commands toward the analog drivers
	typedef struct packed {
		logic       spindle_hiz;     // spindle stage high impedance
		logic [2:0] spindle_ls_on;   // three spindle low-side drivers
		logic [2:0] spindle_hs_on;   // three spindle high-side drivers
		logic       vcm_neg_ls_on;   // low side of vcm_neg_output
		logic       vcm_others_on;   // any other VCM driver allowed
		logic       vcm_precharge;   // precharge both VCM outputs
		logic       vcm_cmd_short;   // vcm_command_input to ground
		logic       park_circ_en;    // park circuit powered
		logic       brake_dly_short; // brake_delay_node to ground
		logic       seek_gain_sel;   // 1 high-gain seek, 0 track-follow
	} bapsq_drive_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} bapsq_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} bapsq_axi_rsp_t;

endpackage : bapsq_pkg

/* tb/bapsq_stage_model.sv */
// far-side model: supply comparators, brake-delay rc node, over-temperature comparator
`timescale 1ns/10ps
`default_nettype none
module bapsq_stage_model
	import bapsq_pkg::*;
#(
	parameter int RC_CYC = 30 // cycles for the rc node to fall below threshold
) (
	input  wire logic                    aclk,       // clock
	input  wire bapsq_pkg::bapsq_drive_t drive,      // power commands from the block
	input  wire logic                    supply_ok,  // both supplies above threshold
	input  wire logic                    hot,        // die above shutdown limit
	output var  logic                    low_ok,     // low supply comparator
	output var  logic                    high_ok,    // high supply comparator
	output var  logic                    node_above, // brake-delay comparator
	output var  logic                    over_temp   // over-temperature comparator
);
	int cnt = RC_CYC;

	assign low_ok = supply_ok;
	assign high_ok = supply_ok;
	assign over_temp = hot;
	// node discharges while parking and is held at ground in brake; recharge in run keeps the park time honest
	always @(posedge aclk) begin
		if (drive.brake_dly_short === 1'h1)
			cnt <= 0;
		else if (drive.vcm_neg_ls_on === 1'h1)
			cnt <= (cnt > 0) ? cnt - 1 : 0;
		else
			cnt <= RC_CYC;
	end
	assign node_above = (cnt != 0);
endmodule : bapsq_stage_model
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the brake-after-park sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import bapsq_pkg::*;
	logic           aclk = 0;
	logic           aresetn = 0;
	logic           supply_ok = 0;
	logic           hot = 0;
	logic           low_ok, high_ok, node_above, over_temp, por_n, fault, temp_alarm;
	bapsq_axi_req_t req = '0;
	bapsq_axi_rsp_t rsp;
	bapsq_drive_t   drive;
	logic           sg = 1'h1;
	logic           ce = 1'h1;
	logic [31:0]    rd;
	logic [1:0]     rs;
	int             errors = 0;
	int             num_checks = 0;
	int             cycles = 0;
	int             n;

	bapsq_top #(.POR_DLY_CYC(20)) dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
		.axi_req(req), .axi_rsp(rsp), .low_supply_check(low_ok), .high_supply_check(high_ok),
		.brake_delay_above(node_above), .temp_over(over_temp), .por_n(por_n), .fault(fault),
		.temp_alarm(temp_alarm), .drive(drive));
	bapsq_stage_model #(.RC_CYC(30)) stage_u (.aclk(aclk), .drive(drive), .supply_ok(supply_ok),
		.hot(hot), .low_ok(low_ok), .high_ok(high_ok), .node_above(node_above),
		.over_temp(over_temp));

	initial forever #2.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic bapsq_drive_t park_d();
		return '{1'h1, 3'h0, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, sg};
	endfunction : park_d

	function automatic bapsq_drive_t brake_d();
		return '{1'h0, 3'h7, 3'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, sg};
	endfunction : brake_d

	// polls at the falling edge so registered outputs have settled
	task automatic wait_drive(input bapsq_drive_t e, input int lim);
		for (n = 0; n < lim && drive !== e; n++)
			@(negedge aclk);
	endtask : wait_drive

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b, ta, tw;
		@(posedge aclk);
		req.awaddr <= {24'h0, a};
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'h1;
		req.wvalid <= 1'h1;
		req.bready <= 1'h1;
		aw = 1;
		w = 1;
		b = 0;
		r = 2'h3;
		while (!b) begin
			@(negedge aclk);
			ta = aw & rsp.awready;
			tw = w & rsp.wready;
			b = rsp.bvalid;
			if (b)
				r = rsp.bresp;
			@(posedge aclk);
			if (ta) begin
				aw = 0;
				req.awvalid <= 1'h0;
			end
			if (tw) begin
				w = 0;
				req.wvalid <= 1'h0;
			end
			if (b)
				req.bready <= 1'h0;
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rh, ta;
		@(posedge aclk);
		req.araddr <= {24'h0, a};
		req.arvalid <= 1'h1;
		req.rready <= 1'h1;
		ar = 1;
		rh = 0;
		while (!rh) begin
			@(negedge aclk);
			ta = ar & rsp.arready;
			rh = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge aclk);
			if (ta) begin
				ar = 0;
				req.arvalid <= 1'h0;
			end
			if (rh)
				req.rready <= 1'h0;
		end
	endtask : axr

	task automatic spin_and_check();
		axw(BAPSQ_CTRL1_OFF, 32'h208, rs);
		sg = 1'h0;
		chk("write resp", BAPSQ_RESP_OKAY, rs);
		repeat (6) @(negedge aclk);
		axr(BAPSQ_STATUS_OFF, rd, rs);
		chk("state run", 32'h0, rd & 32'h3);
		chk("seek gain", 32'h0, drive.seek_gain_sel);
	endtask : spin_and_check

	////////////////////////////////////////////////////////////////////////////////
	task t_power();
		@(negedge aclk);
		chk("reset drive", park_d(), drive);
		chk("fault", 1, fault);
		@(posedge aclk);
		supply_ok <= 1'h1;
		repeat (15) @(negedge aclk);
		chk("por_n early", 0, por_n);
		for (n = 0; n < 60 && por_n !== 1'h1; n++)
			@(negedge aclk);
		chk("por_n", 1, por_n);
		wait_drive(brake_d(), 100);
		repeat (20) @(negedge aclk);
		chk("held brake", brake_d(), drive);
		axr(BAPSQ_CTRL1_OFF, rd, rs);
		chk("ctrl1 default", BAPSQ_CTRL1_RST, rd);
		axr(BAPSQ_CTRL0_OFF, rd, rs);
		chk("ctrl0 default", BAPSQ_CTRL0_RST, rd);
		axr(8'h0C, rd, rs);
		chk("unmapped resp", BAPSQ_RESP_SLVERR, rs);
		chk("unmapped data", 0, rd);
		spin_and_check();
		$display("test power done");
	endtask : t_power

	task t_sleep();
		axw(BAPSQ_CTRL1_OFF, 32'h201, rs);
		for (n = 0; n < 10 && fault !== 1'h1; n++)
			@(negedge aclk);
		chk("sleep fault", 1, fault);
		wait_drive(park_d(), 10);
		chk("park drive", park_d(), drive);
		repeat (20) @(negedge aclk);
		chk("still park", park_d(), drive);
		// the node falls while frozen; the sequencer must not move until enabled
		@(posedge aclk);
		ce <= 1'h0;
		repeat (20) @(negedge aclk);
		chk("frozen park", park_d(), drive);
		@(posedge aclk);
		ce <= 1'h1;
		wait_drive(brake_d(), 30);
		chk("brake drive", brake_d(), drive);
		spin_and_check();
		$display("test sleep done");
	endtask : t_sleep

	task t_thermal();
		// a gain rewrite while running carries the spin bit; it must not end the coming brake
		axw(BAPSQ_CTRL1_OFF, 32'h208, rs);
		chk("rewrite resp", BAPSQ_RESP_OKAY, rs);
		@(posedge aclk);
		hot <= 1'h1;
		for (n = 0; n < 10 && temp_alarm !== 1'h1; n++)
			@(negedge aclk);
		chk("temp alarm", 1, temp_alarm);
		wait_drive(park_d(), 10);
		chk("tsd park", park_d(), drive);
		wait_drive(brake_d(), 60);
		@(posedge aclk);
		hot <= 1'h0;
		for (n = 0; n < 10 && temp_alarm !== 1'h0; n++)
			@(negedge aclk);
		chk("temp alarm off", 0, temp_alarm);
		repeat (10) @(negedge aclk);
		chk("tsd brake held", brake_d(), drive);
		spin_and_check();
		$display("test thermal done");
	endtask : t_thermal

	task t_glitch();
		int lows;
		lows = 0;
		axw(BAPSQ_CTRL0_OFF, 32'h5A5, rs);
		chk("ctrl0 write resp", BAPSQ_RESP_OKAY, rs);
		axr(BAPSQ_CTRL0_OFF, rd, rs);
		chk("ctrl0 readback", 32'h5A5, rd);
		@(posedge aclk);
		supply_ok <= 1'h0;
		repeat (3) @(posedge aclk);
		supply_ok <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			lows += (por_n !== 1'h1);
		end
		chk("spike lows", 0, lows);
		@(posedge aclk);
		supply_ok <= 1'h0;
		for (n = 0; n < 30 && por_n !== 1'h0; n++)
			@(negedge aclk);
		chk("por_n drop", 0, por_n);
		repeat (3) @(negedge aclk);
		chk("drop fault", 1, fault);
		axr(BAPSQ_CTRL0_OFF, rd, rs);
		chk("ctrl0 under reset", BAPSQ_CTRL0_RST, rd);
		axr(BAPSQ_CTRL1_OFF, rd, rs);
		chk("ctrl1 under reset", BAPSQ_CTRL1_RST, rd);
		$display("test glitch done");
	endtask : t_glitch

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_power();
		t_sleep();
		t_thermal();
		t_glitch();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
